// >>> src/bemq_top.sv
// Bus event mask qualifier with Wishbone register access and two event counters
`timescale 1ns/100ps
`include "bemq_defs.svh"
module bemq_top (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire bemq_pkg::bemq_word_t wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic dbus_occ_in,
	input wire logic dbus_is_busy_in,
	input wire logic dbus_sampled_in,
	input wire logic dbus_full_line_in,
	input wire logic alloc_valid_in,
	input wire bemq_pkg::bemq_code2_t alloc_kind_in,
	input wire bemq_pkg::bemq_code2_t alloc_length_in,
	input wire logic alloc_io_in,
	input wire logic alloc_lock_in,
	input wire logic alloc_cache_in,
	input wire logic alloc_split_in,
	input wire logic alloc_demand_in,
	input wire logic alloc_ordered_in,
	output logic bus_tick_out,
	output logic act_cond_out,
	output logic alloc_hit_out,
	output logic irq_out
);
	import bemq_pkg::*;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic bemq_word_t apply_sel(input bemq_word_t old_v, input bemq_word_t new_v,
		input logic [3:0] sel);
		bemq_word_t r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : apply_sel

	// Hold length of one sub-event in processor clocks
	function automatic bemq_hold_t hold_len(input bemq_sub_e sub, input logic full);
		bemq_hold_t h;
		h = `BEMQ_HOLD_NONE;
		case (sub)
			BEMQ_DB_SAMPLED: h = full ? `BEMQ_HOLD_SHORT : `BEMQ_HOLD_NONE;
			BEMQ_DB_UNSAMPLED: h = full ? `BEMQ_HOLD_LONG : `BEMQ_HOLD_SHORT;
			BEMQ_DR_SAMPLED: h = full ? `BEMQ_HOLD_LONG : `BEMQ_HOLD_SHORT;
			BEMQ_DR_UNSAMPLED: h = full ? `BEMQ_HOLD_LONG : `BEMQ_HOLD_SHORT;
			default: h = `BEMQ_HOLD_NONE;
		endcase
		return h;
	endfunction : hold_len

	// Mask bit that enables a sub-event
	function automatic logic sub_enabled(input bemq_sub_e sub, input logic [15:0] m);
		logic e;
		e = 1'b0;
		case (sub)
			BEMQ_DR_SAMPLED: e = m[`BEMQ_M_DR_SAMPLED];
			BEMQ_DR_UNSAMPLED: e = m[`BEMQ_M_DR_UNSAMPLED];
			BEMQ_DB_SAMPLED: e = m[`BEMQ_M_DB_SAMPLED];
			BEMQ_DB_UNSAMPLED: e = m[`BEMQ_M_DB_UNSAMPLED];
			default: e = 1'b0;
		endcase
		return e;
	endfunction : sub_enabled

	// Control word enabled and carrying the expected select code
	function automatic logic sel_match(input bemq_word_t ctl, input logic [6:0] code);
		return ctl[`BEMQ_EN_BIT] && (ctl[`BEMQ_ESEL_HI:`BEMQ_ESEL_LO] == code);
	endfunction : sel_match

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	bemq_word_t act_ctl_q;
	bemq_word_t alloc_ctl_q;
	bemq_word_t act_cnt_q;
	bemq_word_t alloc_cnt_q;
	logic [`BEMQ_IRQ_W-1:0] irq_stat_q;
	logic [`BEMQ_IRQ_W-1:0] irq_mask_q;
	logic bus_req;
	logic wr_en;
	bemq_word_t rd_d;

	assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign wr_en = bus_req && wb_we_in;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wb_ack_out <= 1'b0;
		end else begin
			wb_ack_out <= bus_req;
		end
	end

	always_comb begin
		rd_d = `BEMQ_ZERO32;
		case (wb_adr_in)
			`BEMQ_OFF_ACT_CTL: rd_d = act_ctl_q;
			`BEMQ_OFF_ALLOC_CTL: rd_d = alloc_ctl_q;
			`BEMQ_OFF_ACT_CNT: rd_d = act_cnt_q;
			`BEMQ_OFF_ALLOC_CNT: rd_d = alloc_cnt_q;
			`BEMQ_OFF_IRQ_STAT: rd_d = {30'h0, irq_stat_q};
			`BEMQ_OFF_IRQ_MASK: rd_d = {30'h0, irq_mask_q};
			default: rd_d = `BEMQ_ZERO32;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wb_dat_out <= `BEMQ_ZERO32;
		end else if (bus_req && !wb_we_in) begin
			wb_dat_out <= rd_d;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			act_ctl_q <= `BEMQ_ZERO32;
			alloc_ctl_q <= `BEMQ_ZERO32;
			irq_mask_q <= '0;
		end else if (wr_en) begin
			case (wb_adr_in)
				`BEMQ_OFF_ACT_CTL: act_ctl_q <= apply_sel(act_ctl_q, wb_dat_in, wb_sel_in);
				`BEMQ_OFF_ALLOC_CTL: alloc_ctl_q <= apply_sel(alloc_ctl_q, wb_dat_in, wb_sel_in);
				`BEMQ_OFF_IRQ_MASK: begin
					if (wb_sel_in[0]) begin
						irq_mask_q <= wb_dat_in[`BEMQ_IRQ_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Bus clock enable
	// ----------------------------------------------------------------
	logic [1:0] div_q;
	// Occurrences on the data activity link are only taken on this tick

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			div_q <= 2'h0;
			bus_tick_out <= 1'b0;
		end else begin
			div_q <= (div_q == `BEMQ_BUS_RATIO - 2'h1) ? 2'h0 : div_q + 2'h1;
			bus_tick_out <= (div_q == `BEMQ_BUS_RATIO - 2'h1);
		end
	end

	// ----------------------------------------------------------------
	// Data activity sub-events
	// ----------------------------------------------------------------
	bemq_hold_t hold_q [`BEMQ_NSUB];
	logic [`BEMQ_NSUB-1:0] start_d;
	logic [`BEMQ_NSUB-1:0] live_d;
	bemq_sub_e occ_sub;
	logic act_sel;
	logic act_level;
	logic act_start;

	// Sampled flag picks exactly one of each pair
	always_comb begin
		occ_sub = BEMQ_DR_SAMPLED;
		case ({dbus_is_busy_in, dbus_sampled_in})
			2'h3: occ_sub = BEMQ_DB_SAMPLED;
			2'h2: occ_sub = BEMQ_DB_UNSAMPLED;
			2'h1: occ_sub = BEMQ_DR_SAMPLED;
			2'h0: occ_sub = BEMQ_DR_UNSAMPLED;
			default: occ_sub = BEMQ_DR_SAMPLED;
		endcase
	end

	always_comb begin
		for (int i = 0; i < `BEMQ_NSUB; i++) begin
			start_d[i] = bus_tick_out && dbus_occ_in && (occ_sub == bemq_sub_e'(i))
				&& (hold_len(occ_sub, dbus_full_line_in) != `BEMQ_HOLD_NONE);
		end
	end

	// A new occurrence reloads the hold, so stalled repeats each restart it
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			for (int i = 0; i < `BEMQ_NSUB; i++) begin
				hold_q[i] <= `BEMQ_HOLD_NONE;
			end
		end else begin
			for (int i = 0; i < `BEMQ_NSUB; i++) begin
				if (start_d[i]) begin
					hold_q[i] <= hold_len(occ_sub, dbus_full_line_in);
				end else if (hold_q[i] != `BEMQ_HOLD_NONE) begin
					hold_q[i] <= hold_q[i] - 3'h1;
				end
			end
		end
	end

	logic [`BEMQ_NSUB-1:0] began_q;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			began_q <= '0;
		end else begin
			began_q <= start_d;
		end
	end

	always_comb begin
		for (int i = 0; i < `BEMQ_NSUB; i++) begin
			live_d[i] = (hold_q[i] != `BEMQ_HOLD_NONE)
				&& sub_enabled(bemq_sub_e'(i), act_ctl_q[`BEMQ_EMASK_HI:`BEMQ_EMASK_LO]);
		end
	end

	assign act_sel = sel_match(act_ctl_q, `BEMQ_CODE_ACT);
	assign act_level = act_sel && (|live_d);
	assign act_start = act_sel && (|(live_d & began_q));

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			act_cond_out <= 1'b0;
		end else begin
			act_cond_out <= act_level;
		end
	end

	// ----------------------------------------------------------------
	// Queue allocation qualification
	// ----------------------------------------------------------------
	logic [15:0] am;
	logic alloc_match;

	assign am = alloc_ctl_q[`BEMQ_EMASK_HI:`BEMQ_EMASK_LO];

	always_comb begin
		alloc_match = alloc_valid_in;
		if (alloc_kind_in != am[`BEMQ_M_KIND_HI:`BEMQ_M_KIND_LO]) begin
			alloc_match = 1'b0;
		end
		if (alloc_length_in != am[`BEMQ_M_LEN_HI:`BEMQ_M_LEN_LO]) begin
			alloc_match = 1'b0;
		end
		if (am[`BEMQ_M_IO] && !alloc_io_in) begin
			alloc_match = 1'b0;
		end
		if (am[`BEMQ_M_LOCK] && !alloc_lock_in) begin
			alloc_match = 1'b0;
		end
		if (am[`BEMQ_M_CACHE] && !alloc_cache_in) begin
			alloc_match = 1'b0;
		end
		if (am[`BEMQ_M_SPLIT] && !alloc_split_in) begin
			alloc_match = 1'b0;
		end
		if (am[`BEMQ_M_DEMAND] != alloc_demand_in) begin
			alloc_match = 1'b0;
		end
		if (am[`BEMQ_M_ORDERED] && !alloc_ordered_in) begin
			alloc_match = 1'b0;
		end
		if (!sel_match(alloc_ctl_q, `BEMQ_CODE_ALLOC)) begin
			alloc_match = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			alloc_hit_out <= 1'b0;
		end else begin
			alloc_hit_out <= alloc_match;
		end
	end

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	logic act_inc;
	logic act_wrap;
	logic alloc_wrap;
	logic act_cnt_wr;
	logic alloc_cnt_wr;

	// A software write to a counter wins over an increment in the same cycle
	assign act_cnt_wr = wr_en && (wb_adr_in == `BEMQ_OFF_ACT_CNT);
	assign alloc_cnt_wr = wr_en && (wb_adr_in == `BEMQ_OFF_ALLOC_CNT);

	// Edge mode counts each enabled sub-event hold start, restarts while held included; level mode counts held cycles
	assign act_inc = act_ctl_q[`BEMQ_EDGE_BIT] ? act_start : act_level;
	// An increment replaced by a write flags no wrap
	assign act_wrap = act_inc && !act_cnt_wr && (act_cnt_q == `BEMQ_ONES32);
	assign alloc_wrap = alloc_match && !alloc_cnt_wr && (alloc_cnt_q == `BEMQ_ONES32);

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			act_cnt_q <= `BEMQ_ZERO32;
		end else if (act_cnt_wr) begin
			act_cnt_q <= apply_sel(act_cnt_q, wb_dat_in, wb_sel_in);
		end else if (act_inc) begin
			act_cnt_q <= act_cnt_q + `BEMQ_ONE32;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			alloc_cnt_q <= `BEMQ_ZERO32;
		end else if (alloc_cnt_wr) begin
			alloc_cnt_q <= apply_sel(alloc_cnt_q, wb_dat_in, wb_sel_in);
		end else if (alloc_match) begin
			alloc_cnt_q <= alloc_cnt_q + `BEMQ_ONE32;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	logic [`BEMQ_IRQ_W-1:0] irq_clr;
	logic [`BEMQ_IRQ_W-1:0] irq_set;

	assign irq_clr = (wr_en && wb_adr_in == `BEMQ_OFF_IRQ_STAT && wb_sel_in[0])
		? wb_dat_in[`BEMQ_IRQ_W-1:0] : '0;
	assign irq_set = {alloc_wrap, act_wrap};

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
		end
	end

	// Status changes reach the pin at once, mask writes one cycle later
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
		end
	end
endmodule : bemq_top

// >>> src/bemq_defs.svh
// Register map, field positions and timing constants of the bus event mask qualifier
`ifndef BEMQ_DEFS_SVH
`define BEMQ_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define BEMQ_OFF_ACT_CTL 8'h00
`define BEMQ_OFF_ALLOC_CTL 8'h04
`define BEMQ_OFF_ACT_CNT 8'h08
`define BEMQ_OFF_ALLOC_CNT 8'h0C
`define BEMQ_OFF_IRQ_STAT 8'h10
`define BEMQ_OFF_IRQ_MASK 8'h14

// ----------------------------------------------------------------
// Event select control layout
// ----------------------------------------------------------------
`define BEMQ_ESEL_HI 31
`define BEMQ_ESEL_LO 25
`define BEMQ_EMASK_HI 24
`define BEMQ_EMASK_LO 9
`define BEMQ_EN_BIT 0
`define BEMQ_EDGE_BIT 1
`define BEMQ_CODE_ACT 7'h17
`define BEMQ_CODE_ALLOC 7'h05

// ----------------------------------------------------------------
// Data activity mask bits
// ----------------------------------------------------------------
`define BEMQ_M_DR_SAMPLED 1
`define BEMQ_M_DR_UNSAMPLED 2
`define BEMQ_M_DB_SAMPLED 4
`define BEMQ_M_DB_UNSAMPLED 5

// ----------------------------------------------------------------
// Queue allocation mask bits
// ----------------------------------------------------------------
`define BEMQ_M_KIND_HI 1
`define BEMQ_M_KIND_LO 0
`define BEMQ_M_LEN_HI 3
`define BEMQ_M_LEN_LO 2
`define BEMQ_M_IO 5
`define BEMQ_M_LOCK 6
`define BEMQ_M_CACHE 7
`define BEMQ_M_SPLIT 8
`define BEMQ_M_DEMAND 9
`define BEMQ_M_ORDERED 10

// ----------------------------------------------------------------
// Interrupt status bits and reset values
// ----------------------------------------------------------------
`define BEMQ_IRQ_ACT 0
`define BEMQ_IRQ_ALLOC 1
`define BEMQ_IRQ_W 2
`define BEMQ_ZERO32 32'h0000_0000
`define BEMQ_ONES32 32'hFFFF_FFFF
`define BEMQ_ONE32 32'h0000_0001

// ----------------------------------------------------------------
// Timing in processor clocks
// ----------------------------------------------------------------
`define BEMQ_HOLD_SHORT 3'h2
`define BEMQ_HOLD_LONG 3'h4
`define BEMQ_HOLD_NONE 3'h0
`define BEMQ_BUS_RATIO 2'h2
`define BEMQ_NSUB 4

`endif

// >>> src/bemq_pkg.sv
// Types shared by the bus event mask qualifier
package bemq_pkg;
	typedef enum logic [1:0] {
		BEMQ_DR_SAMPLED,
		BEMQ_DR_UNSAMPLED,
		BEMQ_DB_SAMPLED,
		BEMQ_DB_UNSAMPLED
	} bemq_sub_e;
	typedef logic [2:0] bemq_hold_t;
	typedef logic [1:0] bemq_code2_t;
	typedef logic [31:0] bemq_word_t;
endpackage : bemq_pkg

// >>> dv/bemq_bus_agent.sv
// Model of the other agents on the front side bus
`timescale 1ns/100ps
module bemq_bus_agent (
	input wire logic clk_in,
	input wire logic tick_in,
	output logic occ_out,
	output logic busy_out,
	output logic smp_out,
	output logic full_out
);
	initial begin
		occ_out = 1'b0;
		{busy_out, smp_out, full_out} = 3'h5;
	end
	// One occurrence on the next bus tick; attributes scrambled once it has passed
	task automatic occur(input logic b, input logic s, input logic f);
		do @(posedge clk_in); while (tick_in !== 1'b0);
		occ_out <= 1'b1;
		{busy_out, smp_out, full_out} <= {b, s, f};
		@(posedge clk_in);
		occ_out <= 1'b0;
		{busy_out, smp_out, full_out} <= ~{b, s, f};
	endtask : occur
endmodule : bemq_bus_agent

// >>> dv/bemq_top_properties.sv
// Port checks of the bus event mask qualifier
`timescale 1ns/100ps
module bemq_top_properties (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic wb_ack_out,
	input wire logic dbus_occ_in,
	input wire logic dbus_is_busy_in,
	input wire logic dbus_sampled_in,
	input wire logic dbus_full_line_in,
	input wire logic alloc_valid_in,
	input wire logic bus_tick_out,
	input wire logic act_cond_out,
	input wire logic alloc_hit_out,
	input wire logic irq_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	a_ack_one_pulse: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held over one cycle");
	a_ack_next_cycle: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("request not answered next cycle");
	a_tick_period: assert property (bus_tick_out |=> !bus_tick_out ##1 bus_tick_out)
		else $error("bus tick not every second clock");
	a_hit_after_alloc: assert property (alloc_hit_out |-> $past(alloc_valid_in))
		else $error("hit without allocation");
	a_cond_from_tick: assert property ($rose(act_cond_out) |->
		$past(bus_tick_out, 2) && $past(dbus_occ_in, 2))
		else $error("condition without ticked occurrence");
	a_busy_full_only: assert property ($rose(act_cond_out) && $past(dbus_is_busy_in, 2)
		&& $past(dbus_sampled_in, 2) |-> $past(dbus_full_line_in, 2))
		else $error("sampled busy on partial line");
	a_cond_min_two: assert property ($rose(act_cond_out) |-> act_cond_out[*2])
		else $error("condition shorter than two clocks");
	a_irq_drop_write: assert property ($fell(irq_out) |->
		$past(wb_cyc_in && wb_stb_in && wb_we_in))
		else $error("irq fell without a write");
	c_alloc_hit: cover property (alloc_hit_out);
	c_cond_four: cover property (act_cond_out[*4]);
	c_irq_rise: cover property ($rose(irq_out));
endmodule : bemq_top_properties
bind bemq_top bemq_top_properties u_props (.clk_in, .srst_in, .wb_cyc_in, .wb_stb_in,
	.wb_we_in, .wb_ack_out, .dbus_occ_in, .dbus_is_busy_in, .dbus_sampled_in,
	.dbus_full_line_in, .alloc_valid_in, .bus_tick_out, .act_cond_out, .alloc_hit_out,
	.irq_out);

// >>> dv/tb_top.sv
// Self-checking bench for the bus event mask qualifier
`timescale 1ns/100ps
`include "bemq_defs.svh"
module tb_top;
	import bemq_pkg::*;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic wb_cyc_in = 1'b0;
	logic wb_stb_in = 1'b0;
	logic wb_we_in = 1'b0;
	logic [7:0] wb_adr_in = 8'h00;
	logic [3:0] wb_sel_in = 4'hF;
	bemq_word_t wb_dat_in = 32'h0, rdat;
	logic [31:0] wb_dat_out;
	logic wb_ack_out, dbus_occ_in, dbus_is_busy_in, dbus_sampled_in, dbus_full_line_in;
	logic alloc_valid_in = 1'b0;
	bemq_code2_t alloc_kind_in = 2'h0, alloc_length_in = 2'h0;
	logic [5:0] at = 6'h00;
	logic bus_tick_out, act_cond_out, alloc_hit_out, irq_out;
	int n_errors = 0, num_checks = 0, ticks = 0, nexp, ncond;
	always #2 clk_in = ~clk_in;
	bemq_top dut (.clk_in, .srst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
		.wb_dat_in, .wb_dat_out, .wb_ack_out, .dbus_occ_in, .dbus_is_busy_in, .dbus_sampled_in,
		.dbus_full_line_in, .alloc_valid_in, .alloc_kind_in, .alloc_length_in,
		.alloc_io_in(at[0]), .alloc_lock_in(at[1]), .alloc_cache_in(at[2]),
		.alloc_split_in(at[3]), .alloc_demand_in(at[4]), .alloc_ordered_in(at[5]),
		.bus_tick_out, .act_cond_out, .alloc_hit_out, .irq_out);
	bemq_bus_agent agent (.clk_in, .tick_in(bus_tick_out), .occ_out(dbus_occ_in),
		.busy_out(dbus_is_busy_in), .smp_out(dbus_sampled_in), .full_out(dbus_full_line_in));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic wb(input logic w, input logic [7:0] a, input bemq_word_t d);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= w;
		wb_adr_in <= a;
		wb_dat_in <= d;
		do @(posedge clk_in); while (wb_ack_out !== 1'b1);
		rdat = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		@(posedge clk_in);
	endtask : wb
	function automatic bemq_word_t ctl(input logic [6:0] c, input int m, input logic e);
		return {c, 16'(m), 7'h00, e, 1'b1};
	endfunction : ctl
	task automatic alloc(input bemq_code2_t k, input bemq_code2_t l, input logic [5:0] a,
		input logic e);
		alloc_valid_in <= 1'b1;
		alloc_kind_in <= k;
		alloc_length_in <= l;
		at <= a;
		@(posedge clk_in);
		alloc_valid_in <= 1'b0;
		at <= ~a;
		@(posedge clk_in);
		chk("alloc hit", 32'(e), 32'(alloc_hit_out));
		nexp += int'(e);
	endtask : alloc
	always @(posedge clk_in) begin
		ticks <= ticks + 1;
		if (ticks == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (12) @(posedge clk_in);
		srst_in <= 1'b0;
		@(posedge clk_in);
		wb(1'b1, 8'h18, 32'hFFFF_FFFF);
		for (int i = 0; i < 7; i++) begin
			wb(1'b0, 8'(4 * i), 32'h0);
			chk("reset read", 32'h0, rdat);
		end
		// Every sub-event kind, then with the opposite sampled mask bit
		for (int c = 0; c < 16; c++) begin
			logic b, s, f, x;
			{x, b, s, f} = 4'(c);
			nexp = x ? 0 : (b && s) ? (f ? 2 : 0) : (f ? 4 : 2);
			wb(1'b1, `BEMQ_OFF_ACT_CTL,
				ctl(`BEMQ_CODE_ACT, 1 << (b ? 5 - (s ^ x) : 2 - (s ^ x)), 1'b0));
			wb(1'b1, `BEMQ_OFF_ACT_CNT, 32'h0);
			agent.occur(b, s, f);
			ncond = 0;
			repeat (8) begin
				@(posedge clk_in);
				ncond += int'(act_cond_out === 1'b1);
			end
			chk("cond cycles", 32'(nexp), 32'(ncond));
			wb(1'b0, `BEMQ_OFF_ACT_CNT, 32'h0);
			chk("act count", 32'(nexp), rdat);
		end
		wb(1'b1, `BEMQ_OFF_ACT_CTL, ctl(`BEMQ_CODE_ACT, 1 << 4, 1'b1));
		wb(1'b1, `BEMQ_OFF_ACT_CNT, 32'h0);
		repeat (3) agent.occur(1'b1, 1'b1, 1'b1);
		wb(1'b1, `BEMQ_OFF_ACT_CTL, ctl(`BEMQ_CODE_ALLOC, 1 << 4, 1'b1));
		agent.occur(1'b1, 1'b1, 1'b1);
		repeat (8) @(posedge clk_in);
		wb(1'b0, `BEMQ_OFF_ACT_CNT, 32'h0);
		chk("stall count", 32'h3, rdat);
		nexp = 0;
		for (int k = 0; k < 4; k++) begin
			for (int l = 0; l < 4; l++) begin
				if (l == 2) continue;
				wb(1'b1, `BEMQ_OFF_ALLOC_CTL, ctl(`BEMQ_CODE_ALLOC, 4 * l + k, 1'b0));
				alloc(2'(k), 2'(l), 6'h2F, 1'b1);
				alloc(2'(k + 1), 2'(l), 6'h00, 1'b0);
				alloc(2'(k), 2'(l ^ 1), 6'h00, 1'b0);
				alloc(2'(k), 2'(l), 6'h10, 1'b0);
			end
		end
		for (int i = 0; i < 6; i++) begin
			wb(1'b1, `BEMQ_OFF_ALLOC_CTL, ctl(`BEMQ_CODE_ALLOC, 32 << i, 1'b0));
			alloc(2'h0, 2'h0, 6'(1 << i), 1'b1);
			alloc(2'h0, 2'h0, 6'h2F & ~6'(1 << i), 1'b0);
		end
		wb(1'b1, `BEMQ_OFF_ALLOC_CTL, ctl(`BEMQ_CODE_ACT, 0, 1'b0));
		alloc(2'h0, 2'h0, 6'h00, 1'b0);
		wb(1'b0, `BEMQ_OFF_ALLOC_CNT, 32'h0);
		chk("alloc count", 32'(nexp), rdat);
		wb(1'b1, `BEMQ_OFF_ALLOC_CTL, ctl(`BEMQ_CODE_ALLOC, 0, 1'b0));
		wb(1'b1, `BEMQ_OFF_ALLOC_CNT, 32'hFFFF_FFFF);
		wb(1'b1, `BEMQ_OFF_IRQ_MASK, 32'h2);
		alloc(2'h0, 2'h0, 6'h00, 1'b1);
		@(posedge clk_in);
		chk("irq set", 32'h1, 32'(irq_out));
		wb(1'b0, `BEMQ_OFF_IRQ_STAT, 32'h0);
		chk("status", 32'h2, rdat);
		wb(1'b1, `BEMQ_OFF_IRQ_MASK, 32'h0);
		chk("irq masked", 32'h0, 32'(irq_out));
		wb(1'b1, `BEMQ_OFF_IRQ_MASK, 32'h2);
		chk("irq unmasked", 32'h1, 32'(irq_out));
		wb(1'b1, `BEMQ_OFF_IRQ_STAT, 32'h2);
		chk("irq cleared", 32'h0, 32'(irq_out));
		wb(1'b0, `BEMQ_OFF_ALLOC_CNT, 32'h0);
		chk("wrapped count", 32'h0, rdat);
		wb_sel_in <= 4'h1;
		wb(1'b1, `BEMQ_OFF_ACT_CNT, 32'hFFFF_FFFF);
		wb_sel_in <= 4'hF;
		wb(1'b0, `BEMQ_OFF_ACT_CNT, 32'h0);
		chk("byte write", 32'h0000_00FF, rdat);
		tally_and_finish();
	end
endmodule : tb_top
